// [design/lts_pkg.sv]
/*
 * Constants for the learned-table and statistics readout block: register
 * indices, indirect select codes, entry and counter field positions, and
 * frame length limits.
 * Assumes a 32-bit AXI4-Lite register bus; each register index is one word.
 */
package lts_pkg;

   // ----------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [9:0] IDX_CTRL = 10'h06e;
   localparam logic [9:0] IDX_ADDR = 10'h06f;
   localparam logic [9:0] IDX_DATA_FIRST = 10'h070;
   localparam logic [9:0] IDX_DATA_LAST = 10'h078;
   localparam logic [9:0] IDX_CFG = 10'h07a;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] IADDR_RST = 8'h00;
   localparam logic [1:0] CFG_RST = 2'h0;
   localparam int CFG_MAX1536_BIT = 0;
   localparam int CFG_JAB1916_BIT = 1;

   // ----------------------------------------------------------------------
   // Indirect control fields
   // ----------------------------------------------------------------------
   localparam int SEL_READ_BIT = 4;
   localparam int SEL_TBL_HI = 3;
   localparam int SEL_TBL_LO = 2;
   localparam logic [1:0] TBL_DYN = 2'h2;
   localparam logic [1:0] TBL_MIB = 2'h3;
   localparam logic [7:0] CMD_DYN_READ = 8'h18;
   localparam logic [7:0] CMD_MIB_READ = 8'h1c;

   // ----------------------------------------------------------------------
   // Learned-table entry layout
   // ----------------------------------------------------------------------
   localparam int ENT_W = 72;
   localparam int ENT_EMPTY_BIT = 71;
   localparam int ENT_CNT_HI = 70;
   localparam int ENT_CNT_LO = 61;
   localparam int ENT_AGE_HI = 60;
   localparam int ENT_AGE_LO = 59;
   localparam int ENT_PORT_HI = 58;
   localparam int ENT_PORT_LO = 56;
   localparam int ENT_BUSY_BIT = 55;
   localparam logic [1:0] AGE_MAX = 2'h3;
   localparam logic [2:0] PORT_CODE_MAX = 3'h4;

   // ----------------------------------------------------------------------
   // Statistics counters
   // ----------------------------------------------------------------------
   localparam int MIB_CNT_W = 30;
   localparam int MIB_OVF_BIT = 31;
   localparam int MIB_VALID_BIT = 30;
   localparam int NCNT = 25;
   localparam int C_RX_LO = 0, C_RX_HI = 1, C_RX_SHORT_GOOD = 2, C_RX_SHORT_BAD = 3;
   localparam int C_RX_LONG_GOOD = 4, C_RX_LONG_BAD = 5, C_RX_SYM = 6, C_RX_CRC = 7;
   localparam int C_RX_ALIGN = 8, C_RX_CTRL = 9, C_RX_PAUSE = 10, C_RX_BC = 11;
   localparam int C_RX_MC = 12, C_RX_UC = 13, C_BIN64 = 14, C_BIN65 = 15;
   localparam int C_BIN128 = 16, C_BIN256 = 17, C_BIN512 = 18, C_BIN1024 = 19;
   localparam int C_TX_LO = 20, C_TX_HI = 21, C_TX_LATE = 22, C_TX_PAUSE = 23;
   localparam int C_TX_BC = 24;

   // ----------------------------------------------------------------------
   // Frame length limits in bytes
   // ----------------------------------------------------------------------
   localparam int LEN_W = 11;
   localparam logic [10:0] LEN_MIN = 11'h040;
   localparam logic [10:0] LEN_127 = 11'h07f;
   localparam logic [10:0] LEN_255 = 11'h0ff;
   localparam logic [10:0] LEN_511 = 11'h1ff;
   localparam logic [10:0] LEN_1023 = 11'h3ff;
   localparam logic [10:0] LEN_MAX_STD = 11'h5f2;
   localparam logic [10:0] LEN_MAX_LONG = 11'h600;
   localparam logic [10:0] LEN_JABBER = 11'h77c;

endpackage

// [design/lts_readout.sv]
/*
 * Learned address table and per-port statistics counters, read by the host
 * through indirect control, address and data registers over AXI4-Lite.
 * Assumes frame and learning events come from logic on clk_sys, one pulse
 * per finished frame, with the attribute inputs valid in that cycle.
 */
//
// Operation
// - Table filled only by hardware, never host
// - Bit 71 set when table holds nothing
// - Bits 70-61 give entry count minus one
// - Bits 60-59 hold two-bit aging counter
// - Bits 58-56 give learning port code
// - Bit 55 high until entry data valid
// - Entry spread over registers 112-120, MSB first
// - Address register write starts table read
// - Separate counter set for every port
// - Offsets 0,1 sum received octets by priority
// - Offsets 2,3 count short good/bad frames
// - Offset 4 counts long good frames
// - Offset 5 counts long errored frames, or all frames over 1916 bytes when CFG_JAB1916_BIT is set
// - Offsets 6,7,8 symbol, check, alignment errors
// - Offsets 9,0xA control and pause frames
// - Offsets 0xB-0xD broadcast, multicast, unicast
// - Offsets 0xE-0x13 six received length bins
// - Offsets 0x14,0x15 transmitted octets by priority
// - Offset 0x16 counts late collisions
// - Offsets 0x17,0x18 tx pause and broadcast
// - Readout: overflow bit31, valid bit30, count
// - Port blocks repeat at 0x20 steps
// - Ten-bit indirect address across two registers
`timescale 1ns/1ps
module lts_readout
   import lts_pkg::*;
#(
   parameter int NPORT = 5,
   parameter int DEPTH = 1024,
   parameter int OP_LAT = 4,
   parameter int AGE_TICK_CYCLES = 200000000
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Address learning
   input wire logic learn_valid,
   input wire logic [47:0] learn_mac,
   input wire logic [6:0] learn_fid,
   input wire logic [2:0] learn_port,
   // Received frame events, one bit per port
   input wire logic [NPORT-1:0] rx_end,
   input wire logic [NPORT-1:0][LEN_W-1:0] rx_len,
   input wire logic [NPORT-1:0] rx_crc_ok,
   input wire logic [NPORT-1:0] rx_sym_err,
   input wire logic [NPORT-1:0] rx_odd_bits,
   input wire logic [NPORT-1:0] rx_hi_prio,
   input wire logic [NPORT-1:0] rx_bcast,
   input wire logic [NPORT-1:0] rx_mcast,
   input wire logic [NPORT-1:0] rx_ctrl_type,
   input wire logic [NPORT-1:0] rx_pause_op,
   // Transmitted frame events, one bit per port
   input wire logic [NPORT-1:0] tx_end,
   input wire logic [NPORT-1:0][LEN_W-1:0] tx_len,
   input wire logic [NPORT-1:0] tx_ok,
   input wire logic [NPORT-1:0] tx_hi_prio,
   input wire logic [NPORT-1:0] tx_pause,
   input wire logic [NPORT-1:0] tx_bcast,
   input wire logic [NPORT-1:0] tx_late_coll,
   // Status
   output logic [$clog2(DEPTH+1)-1:0] tbl_count
);

   localparam int TAW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   // ----------------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------------
   logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
   logic [9:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic wr_fire, ar_fire;
   logic [9:0] ridx;
   logic [7:0] ctrl_q, iaddr_q;
   logic [1:0] cfg_q;
   logic [ENT_W-1:0] data_q;

   assign s_axi_awready = !aw_got_q && !bvalid_q;
   assign s_axi_wready = !w_got_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
   assign ar_fire = s_axi_arvalid && !rvalid_q;
   assign ridx = s_axi_araddr[ADDR_W-1:2];

   function automatic logic mapped(input logic [9:0] idx);
      mapped = (idx == IDX_CTRL) || (idx == IDX_ADDR) || (idx == IDX_CFG) ||
               (idx >= IDX_DATA_FIRST && idx <= IDX_DATA_LAST);
   endfunction

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         waddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            waddr_q <= s_axi_awaddr[ADDR_W-1:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= mapped(waddr_q) ? 2'h0 : 2'h3;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Data registers read one byte each, first index is the top byte
   always_comb begin
      rdata_d = 32'h0;
      rresp_d = 2'h0;
      if (ridx == IDX_CTRL) begin
         rdata_d = {24'h0, ctrl_q};
      end else if (ridx == IDX_ADDR) begin
         rdata_d = {24'h0, iaddr_q};
      end else if (ridx == IDX_CFG) begin
         rdata_d = {30'h0, cfg_q};
      end else if (ridx >= IDX_DATA_FIRST && ridx <= IDX_DATA_LAST) begin
         rdata_d = {24'h0, data_q[8*(IDX_DATA_LAST-ridx) +: 8]};
      end else begin
         rresp_d = 2'h3;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= 2'h0;
      end else if (ar_fire) begin
         rvalid_q <= 1'b1;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Indirect control and configuration registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= CTRL_RST;
         iaddr_q <= IADDR_RST;
         cfg_q <= CFG_RST;
      end else if (wr_fire && wstrb_q[0]) begin
         if (waddr_q == IDX_CTRL) ctrl_q <= wdata_q[7:0];
         if (waddr_q == IDX_ADDR) iaddr_q <= wdata_q[7:0];
         if (waddr_q == IDX_CFG) cfg_q <= wdata_q[1:0];
      end
   end

   // ----------------------------------------------------------------------
   // Learned address table, maintained by hardware only
   // ----------------------------------------------------------------------
   logic [DEPTH-1:0] tvalid_q, hit;
   logic [47:0] tmac_q [DEPTH];
   logic [6:0] tfid_q [DEPTH];
   logic [2:0] tport_q [DEPTH];
   logic [1:0] tage_q [DEPTH];
   logic [TAW-1:0] free_idx;
   logic any_free;
   logic [CW-1:0] pop;
   logic [31:0] age_div_q;
   logic age_tick;

   // Entries are not compacted; holes from aging are reused first
   always_comb begin
      free_idx = '0;
      any_free = 1'b0;
      pop = '0;
      for (int i = DEPTH-1; i >= 0; i--) begin
         if (!tvalid_q[i]) begin
            free_idx = TAW'(i);
            any_free = 1'b1;
         end
         pop = pop + CW'(tvalid_q[i]);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         age_div_q <= '0;
         tbl_count <= '0;
      end else begin
         age_div_q <= age_tick ? 32'h0 : age_div_q + 32'h1;
         tbl_count <= pop;
      end
   end
   assign age_tick = (age_div_q == 32'(AGE_TICK_CYCLES - 1));

   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      assign hit[i] = tvalid_q[i] && tmac_q[i] == learn_mac && tfid_q[i] == learn_fid;
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            tvalid_q[i] <= 1'b0;
            tmac_q[i] <= '0;
            tfid_q[i] <= '0;
            tport_q[i] <= '0;
            tage_q[i] <= '0;
         end else if (learn_valid && hit[i]) begin
            tage_q[i] <= '0;
            tport_q[i] <= learn_port;
         end else if (learn_valid && !(|hit) && any_free && free_idx == TAW'(i)) begin
            tvalid_q[i] <= 1'b1;
            tmac_q[i] <= learn_mac;
            tfid_q[i] <= learn_fid;
            tport_q[i] <= learn_port;
            tage_q[i] <= '0;
         end else if (age_tick && tvalid_q[i]) begin
            if (tage_q[i] == AGE_MAX) tvalid_q[i] <= 1'b0;
            else tage_q[i] <= tage_q[i] + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Per-port statistics counters
   // ----------------------------------------------------------------------
   logic [MIB_CNT_W-1:0] mib_cnt_q [NPORT][NCNT];
   logic mib_ovf_q [NPORT][NCNT];
   logic [NCNT-1:0] inc [NPORT];

   for (genvar p = 0; p < NPORT; p++) begin : g_port
      logic good, legal, big, sm;
      logic [LEN_W-1:0] lmax, l;
      always_comb begin
         l = rx_len[p];
         lmax = cfg_q[CFG_MAX1536_BIT] ? LEN_MAX_LONG : LEN_MAX_STD;
         good = rx_crc_ok[p] && !rx_sym_err[p] && !rx_odd_bits[p];
         sm = l < LEN_MIN;
         big = l > lmax;
         legal = !sm && !big;
         inc[p] = '0;
         inc[p][C_RX_LO] = rx_end[p] && !rx_hi_prio[p];
         inc[p][C_RX_HI] = rx_end[p] && rx_hi_prio[p];
         inc[p][C_RX_SHORT_GOOD] = rx_end[p] && sm && good;
         inc[p][C_RX_SHORT_BAD] = rx_end[p] && sm && !good;
         inc[p][C_RX_LONG_GOOD] = rx_end[p] && big && good;
         inc[p][C_RX_LONG_BAD] = rx_end[p] && (cfg_q[CFG_JAB1916_BIT] ?
            l > LEN_JABBER : big && !good);
         inc[p][C_RX_SYM] = rx_end[p] && legal && rx_sym_err[p];
         inc[p][C_RX_CRC] = rx_end[p] && legal && !rx_crc_ok[p] && !rx_odd_bits[p];
         inc[p][C_RX_ALIGN] = rx_end[p] && legal && !rx_crc_ok[p] && rx_odd_bits[p];
         inc[p][C_RX_CTRL] = rx_end[p] && rx_ctrl_type[p];
         inc[p][C_RX_PAUSE] = rx_end[p] && rx_ctrl_type[p] && rx_pause_op[p] &&
            !sm && rx_crc_ok[p];
         inc[p][C_RX_BC] = rx_end[p] && good && rx_bcast[p];
         inc[p][C_RX_MC] = rx_end[p] && good && rx_mcast[p] && !rx_bcast[p] &&
            !rx_ctrl_type[p];
         inc[p][C_RX_UC] = rx_end[p] && good && !rx_mcast[p] && !rx_bcast[p];
         inc[p][C_BIN64] = rx_end[p] && l == LEN_MIN;
         inc[p][C_BIN65] = rx_end[p] && l > LEN_MIN && l <= LEN_127;
         inc[p][C_BIN128] = rx_end[p] && l > LEN_127 && l <= LEN_255;
         inc[p][C_BIN256] = rx_end[p] && l > LEN_255 && l <= LEN_511;
         inc[p][C_BIN512] = rx_end[p] && l > LEN_511 && l <= LEN_1023;
         inc[p][C_BIN1024] = rx_end[p] && l > LEN_1023 && !big;
         inc[p][C_TX_LO] = tx_end[p] && tx_ok[p] && !tx_hi_prio[p];
         inc[p][C_TX_HI] = tx_end[p] && tx_ok[p] && tx_hi_prio[p];
         inc[p][C_TX_LATE] = tx_late_coll[p];
         inc[p][C_TX_PAUSE] = tx_end[p] && tx_pause[p];
         inc[p][C_TX_BC] = tx_end[p] && tx_ok[p] && tx_bcast[p];
      end

      // One counter set per port
      for (genvar c = 0; c < NCNT; c++) begin : g_cnt
         logic [MIB_CNT_W:0] sum;
         logic [LEN_W-1:0] amt;
         assign amt = (c == C_RX_LO || c == C_RX_HI) ? rx_len[p] :
                      (c == C_TX_LO || c == C_TX_HI) ? tx_len[p] : LEN_W'(1);
         assign sum = {1'b0, mib_cnt_q[p][c]} + (MIB_CNT_W+1)'(amt);
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               mib_cnt_q[p][c] <= '0;
               mib_ovf_q[p][c] <= 1'b0;
            end else if (inc[p][c]) begin
               mib_cnt_q[p][c] <= sum[MIB_CNT_W-1:0];
               if (sum[MIB_CNT_W]) mib_ovf_q[p][c] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Indirect read engine
   // ----------------------------------------------------------------------
   logic busy_q, op_dyn_q, trig, done;
   logic [2:0] busy_cnt_q;
   logic [9:0] op_addr_q;
   logic [ENT_W-1:0] ent_word;
   logic [31:0] mib_word;
   logic [TAW-1:0] eidx;
   logic [2:0] mport;
   logic [4:0] moff;
   logic mgood;

   // A read starts on the address write while a read select is held;
   // writes, and triggers during a read in progress, are ignored
   assign trig = wr_fire && wstrb_q[0] && waddr_q == IDX_ADDR && !busy_q &&
                 ctrl_q[SEL_READ_BIT] && ctrl_q[SEL_TBL_HI];
   assign done = busy_q && busy_cnt_q == 3'h0;
   assign eidx = op_addr_q[TAW-1:0];
   assign mport = op_addr_q[7:5];
   assign moff = op_addr_q[4:0];
   assign mgood = op_addr_q[9:8] == 2'h0 && 32'(mport) < NPORT && 32'(moff) < NCNT;

   always_comb begin
      ent_word = '0;
      ent_word[ENT_EMPTY_BIT] = tbl_count == '0;
      ent_word[ENT_CNT_HI:ENT_CNT_LO] = (tbl_count == '0) ? 10'h0 :
         10'(tbl_count - CW'(1));
      ent_word[ENT_AGE_HI:ENT_AGE_LO] = tage_q[eidx];
      ent_word[ENT_PORT_HI:ENT_PORT_LO] = tport_q[eidx];
      ent_word[ENT_BUSY_BIT] = 1'b0;
      ent_word[54:0] = {tfid_q[eidx], tmac_q[eidx]};
      mib_word = 32'h0;
      if (mgood) begin
         mib_word[MIB_OVF_BIT] = mib_ovf_q[mport][moff];
         mib_word[MIB_VALID_BIT] = 1'b1;
         mib_word[MIB_CNT_W-1:0] = mib_cnt_q[mport][moff];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         busy_q <= 1'b0;
         busy_cnt_q <= '0;
         op_dyn_q <= 1'b0;
         op_addr_q <= '0;
         data_q <= '0;
      end else if (trig) begin
         busy_q <= 1'b1;
         busy_cnt_q <= 3'(OP_LAT - 1);
         op_dyn_q <= ctrl_q[SEL_TBL_HI:SEL_TBL_LO] == TBL_DYN;
         op_addr_q <= {ctrl_q[1:0], wdata_q[7:0]};
         // Host sees not-ready and rereads from 114
         data_q <= '0;
         data_q[ENT_BUSY_BIT] <= ctrl_q[SEL_TBL_HI:SEL_TBL_LO] == TBL_DYN;
      end else if (done) begin
         busy_q <= 1'b0;
         data_q <= op_dyn_q ? ent_word : {40'h0, mib_word};
      end else if (busy_q) begin
         busy_cnt_q <= busy_cnt_q - 3'h1;
      end
      // Otherwise data_q holds for a consistent multi-byte read
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   logic trig_dyn, trig_mib, wr_data_reg;
   assign trig_dyn = trig && ctrl_q[SEL_TBL_HI:SEL_TBL_LO] == TBL_DYN;
   assign trig_mib = trig && ctrl_q[SEL_TBL_HI:SEL_TBL_LO] == TBL_MIB;
   assign wr_data_reg = wr_fire && waddr_q >= IDX_DATA_FIRST && waddr_q <= IDX_DATA_LAST;

   sequence s_not_ready;
      data_q[ENT_BUSY_BIT] [*4];
   endsequence
   sequence s_ready;
      !data_q[ENT_BUSY_BIT] && !busy_q;
   endsequence

   AST_NOT_READY: assert property (trig_dyn |=> s_not_ready ##1 s_ready)
      else $error("not-ready bit did not span the read latency");
   AST_EMPTY_FLAG: assert property (done && op_dyn_q |=>
      data_q[ENT_EMPTY_BIT] == ($past(tbl_count) == '0))
      else $error("empty flag disagrees with entry count");
   AST_COUNT_FIELD: assert property (done && op_dyn_q && tbl_count != '0 |=>
      data_q[ENT_CNT_HI:ENT_CNT_LO] == 10'($past(tbl_count) - CW'(1)))
      else $error("entry count field is not count minus one");
   AST_PORT_CODE: assert property (done && op_dyn_q |=>
      data_q[ENT_PORT_HI:ENT_PORT_LO] <= PORT_CODE_MAX)
      else $error("learning port code out of range");
   AST_AGE_STEP: assert property (age_tick && tvalid_q[0] && tage_q[0] != AGE_MAX &&
      !learn_valid |=> tage_q[0] == $past(tage_q[0]) + 2'h1)
      else $error("aging counter did not advance on tick");
   AST_HOLD: assert property (!trig && !done |=> $stable(data_q))
      else $error("data registers changed without a trigger");
   AST_NO_HOST_WRITE: assert property (wr_data_reg |=> $stable(tvalid_q)
      or $past(learn_valid) or $past(age_tick))
      else $error("host write altered the learned table");
   AST_MIB_READ: assert property (trig_mib ##1 (!done) [*3] ##1 done |=>
      data_q[MIB_VALID_BIT] == $past(mgood) && data_q[71:32] == 40'h0)
      else $error("counter readout fields wrong");
   AST_BIN64: assert property (rx_end[0] && rx_len[0] == LEN_MIN &&
      !(&mib_cnt_q[0][C_BIN64]) |=> mib_cnt_q[0][C_BIN64] ==
      $past(mib_cnt_q[0][C_BIN64]) + MIB_CNT_W'(1))
      else $error("64-byte bin did not count");
   AST_RX_OCTETS: assert property (rx_end[0] && !rx_hi_prio[0] |=>
      mib_cnt_q[0][C_RX_LO] == $past(mib_cnt_q[0][C_RX_LO]) +
      MIB_CNT_W'($past(rx_len[0])))
      else $error("low-priority octets not accumulated");

endmodule

// [verification/lts_host.sv]
/* Host model: AXI4-Lite master and indirect table and counter reads.
   Assumes the slave shares clk_sys and answers every request. */
`timescale 1ns/1ps
module lts_host
   import lts_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Write channels
   output logic [11:0] s_axi_awaddr, output logic s_axi_awvalid, input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata, output logic s_axi_wvalid, input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp, input wire logic s_axi_bvalid, output logic s_axi_bready,
   // Read channels
   output logic [11:0] s_axi_araddr, output logic s_axi_arvalid, input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata, input wire logic s_axi_rvalid, output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   task wr(input logic [9:0] i, input logic [7:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [9:0] i, output logic [31:0] d);
      @(posedge clk_sys);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   // Select, then trigger; data settles OP_LAT+1 edges after the trigger
   task trig(input logic [7:0] c, input logic [9:0] a);
      logic [1:0] r;
      wr(IDX_CTRL, c | {6'h0, a[9:8]}, r);
      wr(IDX_ADDR, a[7:0], r);
      repeat (5) @(posedge clk_sys);
   endtask
   task entry(input logic [9:0] a, output logic [71:0] e);
      logic [31:0] d;
      trig(CMD_DYN_READ, a);
      for (int n = 0; n < 9; n++) begin
         rd(IDX_DATA_FIRST + 10'(n), d);
         e[71-8*n -: 8] = d[7:0];
         if (n == 2 && d[7]) n = 1; // Not ready: start again at 114
      end
   endtask
   task cnt(input logic [9:0] a, output logic [31:0] w);
      logic [31:0] d;
      trig(CMD_MIB_READ, a);
      for (int n = 5; n < 9; n++) begin
         rd(IDX_DATA_FIRST + 10'(n), d);
         w[71-8*n -: 8] = d[7:0];
      end
   endtask
endmodule

// [verification/lts_readout_tb.sv]
/* Testbench for the table and counter readout, driven through the host model.
   Assumes default NPORT of 5 and the register map of the package. */
`timescale 1ns/1ps
module lts_readout_tb
   import lts_pkg::*;
;
   logic clk_sys = 1'b0, rst_b = 1'b0, learn_valid = 1'b0;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, w;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [47:0] learn_mac = '0;
   logic [6:0] learn_fid = '0;
   logic [2:0] learn_port = '0;
   logic [4:0] rx_end = '0, rx_crc_ok = '0, rx_sym_err = '0, rx_odd_bits = '0, rx_hi_prio = '0;
   logic [4:0] rx_bcast = '0, rx_mcast = '0, rx_ctrl_type = '0, rx_pause_op = '0, tx_end = '0;
   logic [4:0] tx_ok = '0, tx_hi_prio = '0, tx_pause = '0, tx_bcast = '0, tx_late_coll = '0;
   logic [4:0][10:0] rx_len = '0, tx_len = '0;
   logic [4:0] tbl_count;
   logic [71:0] e;
   int errors = 0, num_checks = 0;
   logic [9:0] ca [9] = '{10'h080, 10'h08b, 10'h08e, 10'h082, 10'h021, 10'h022, 10'h014,
      10'h016, 10'h100};
   logic [31:0] cw [9] = '{32'h40000040, 32'h40000001, 32'h40000001, 32'h40000000,
      32'h40000020, 32'h40000001, 32'h40000064, 32'h40000001, 32'h0};
   always #2.5 clk_sys = ~clk_sys;
   lts_host i_host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
   // Aging tick short enough for exactly one tick before the aging read
   lts_readout #(.DEPTH(16), .AGE_TICK_CYCLES(2000)) i_lts_readout (.clk_sys, .rst_b,
      .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .learn_valid, .learn_mac,
      .learn_fid, .learn_port, .rx_end, .rx_len, .rx_crc_ok, .rx_sym_err, .rx_odd_bits,
      .rx_hi_prio, .rx_bcast, .rx_mcast, .rx_ctrl_type, .rx_pause_op, .tx_end, .tx_len, .tx_ok,
      .tx_hi_prio, .tx_pause, .tx_bcast, .tx_late_coll, .tbl_count);
   task check(input logic [71:0] s, input logic [71:0] x);
      num_checks++;
      if (s !== x) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task conclude;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard, well past the few thousand cycles the tests need
   initial begin
      #100000;
      errors++;
      conclude;
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      i_host.entry(10'h0, e);
      check(e, {1'b1, 71'h0});
      $display("empty table read done");
      @(posedge clk_sys);
      {learn_valid, learn_mac, learn_fid, learn_port} <= {1'b1, 48'h0a0b0c0d0e0f, 7'h05, 3'h4};
      {rx_end, rx_crc_ok, rx_hi_prio, rx_bcast} <= {5'h13, 5'h12, 5'h02, 5'h10};
      rx_len <= {11'h040, 22'h0, 11'h020, 11'h040};
      {tx_end, tx_ok, tx_late_coll} <= {5'h01, 5'h01, 5'h01};
      tx_len[0] <= 11'h064;
      @(posedge clk_sys);
      {learn_mac, learn_fid, learn_port} <= {48'h112233445566, 7'h7f, 3'h0};
      {rx_end, tx_end, tx_late_coll} <= '0;
      @(posedge clk_sys);
      learn_valid <= 1'b0;
      i_host.wr(IDX_DATA_FIRST, 8'hff, r);
      check(72'(r), 72'h0);
      i_host.wr(10'h3ff, 8'h01, r);
      check(72'(r), 72'h3);
      i_host.rd(10'h3ff, w);
      check({w, 40'(s_axi_rresp)}, {32'h0, 40'h3});
      i_host.entry(10'h0, e);
      check(e, {1'b0, 10'h1, 2'h0, 3'h4, 1'b0, 7'h05, 48'h0a0b0c0d0e0f});
      i_host.entry(10'h1, e);
      check(e, {1'b0, 10'h1, 2'h0, 3'h0, 1'b0, 7'h7f, 48'h112233445566});
      check(72'(tbl_count), 72'h2);
      $display("learned table read done");
      for (int k = 0; k < 9; k++) begin
         i_host.cnt(ca[k], w);
         check(72'(w), 72'(cw[k]));
      end
      $display("counter read done");
      repeat (2000) @(posedge clk_sys);
      i_host.entry(10'h0, e);
      check(e, {1'b0, 10'h1, 2'h1, 3'h4, 1'b0, 7'h05, 48'h0a0b0c0d0e0f});
      $display("aging read done");
      conclude;
   end
endmodule
